// >>> idc_cfg.svh
`ifndef IDC_CFG_SVH
`define IDC_CFG_SVH

// ****************************************************************
// apb register byte offsets
// ****************************************************************
`define IDC_OFS_CAP       12'h000
`define IDC_OFS_SEL       12'h004
`define IDC_OFS_DMA_TIME  12'h008
`define IDC_OFS_PIO_TIME  12'h00c
`define IDC_OFS_WIDX      12'h010
`define IDC_OFS_WDATA     12'h014
`define IDC_OFS_STATUS    12'h018

// ****************************************************************
// register fields, masks and reset values
// ****************************************************************
`define IDC_CAP_MW_LSB    0
`define IDC_CAP_PIO_LSB   3
`define IDC_CAP_SEC       8
`define IDC_CAP_WC        9
`define IDC_CAP_LA        10
`define IDC_CAP_APM       11
`define IDC_CAP_MASK      32'h0000_0f1f
`define IDC_CAP_RST       32'h0000_0f1f
`define IDC_SEL_VALID     3
`define IDC_SEL_RST       4'h0
`define IDC_DMA_TIME_RST  32'h0000_0000
`define IDC_PIO_TIME_RST  16'h0000
`define IDC_WIDX_RST      8'h00

// ****************************************************************
// identify word indices and fixed contents
// ****************************************************************
`define IDC_ID_WORDS      256
`define IDC_W53           8'h35
`define IDC_W63           8'h3f
`define IDC_W64           8'h40
`define IDC_W65           8'h41
`define IDC_W66           8'h42
`define IDC_W67           8'h43
`define IDC_W68           8'h44
`define IDC_W82           8'h52
`define IDC_W83           8'h53
`define IDC_W84           8'h54
`define IDC_W53_VALID     1
`define IDC_W82_SEC       1
`define IDC_W82_WC        5
`define IDC_W82_LA        6
`define IDC_W83_APM       3
`define IDC_W82_FIXED     16'h7008
`define IDC_W83_FIXED     16'h4004
`define IDC_W84_FIXED     16'h4000

// ****************************************************************
// transfer cycle times in ns
// ****************************************************************
`define IDC_MW0_NS        16'd480
`define IDC_MW1_NS        16'd150
`define IDC_MW2_NS        16'd120
`define IDC_PIO3_NS       16'd180
`define IDC_PIO4_NS       16'd120

`endif

// >>> idc_pkg.sv
package idc_pkg;

   // ****************************************************************
   // shared types
   // ****************************************************************
   typedef logic [15:0] idc_word_t;
   typedef logic [7:0]  idc_idx_t;

   typedef enum logic [1:0] {IDC_IDLE, IDC_LOAD, IDC_SEND} idc_seq_state_t;

   // stream sequencer state
   typedef struct packed {
      idc_seq_state_t state;
      idc_idx_t       idx;
      idc_word_t      data;
   } idc_seq_regs_t;

   // register bank state
   typedef struct packed {
      logic [31:0] cap;
      logic [3:0]  sel;
      logic [31:0] dma_time;
      logic [15:0] pio_time;
      idc_idx_t    widx;
      logic [31:0] rdata;
      logic        err;
   } idc_apb_regs_t;

endpackage

// >>> idc_word_sel.sv
`timescale 1ns/1ps
`include "idc_cfg.svh"

module idc_word_sel (
   // word index
   input  wire idc_pkg::idc_idx_t  idx_i,
   // field words
   input  wire idc_pkg::idc_word_t w53_i,
   input  wire idc_pkg::idc_word_t w63_i,
   input  wire idc_pkg::idc_word_t w64_i,
   input  wire idc_pkg::idc_word_t w65_i,
   input  wire idc_pkg::idc_word_t w66_i,
   input  wire idc_pkg::idc_word_t w67_i,
   input  wire idc_pkg::idc_word_t w68_i,
   input  wire idc_pkg::idc_word_t w82_i,
   input  wire idc_pkg::idc_word_t w83_i,
   input  wire idc_pkg::idc_word_t w84_i,
   // selected word
   output idc_pkg::idc_word_t      word_o
);

   // ****************************************************************
   // index decode, words not held here read as zero
   // ****************************************************************
   always_comb begin
      case (idx_i)
         `IDC_W53: word_o = w53_i;
         `IDC_W63: word_o = w63_i;
         `IDC_W64: word_o = w64_i;
         `IDC_W65: word_o = w65_i;
         `IDC_W66: word_o = w66_i;
         `IDC_W67: word_o = w67_i;
         `IDC_W68: word_o = w68_i;
         `IDC_W82: word_o = w82_i;
         `IDC_W83: word_o = w83_i;
         `IDC_W84: word_o = w84_i;
         default:  word_o = 16'h0000;
      endcase
   end

endmodule

// >>> idc_stream_seq.sv
`timescale 1ns/1ps
`include "idc_cfg.svh"

module idc_stream_seq #(
   parameter int unsigned WORDS = `IDC_ID_WORDS
) (
   // clock and reset
   input  wire logic               sys_clk_i,
   input  wire logic               rstn_i,
   // control
   input  wire logic               start_i,
   input  wire logic               ready_i,
   // word lookup
   input  wire idc_pkg::idc_word_t word_i,
   output idc_pkg::idc_idx_t       idx_o,
   // stream out
   output logic                    valid_o,
   output logic                    busy_o,
   output idc_pkg::idc_word_t      data_o
);

   localparam idc_pkg::idc_idx_t LAST = idc_pkg::idc_idx_t'(WORDS - 1);

   idc_pkg::idc_seq_regs_t seq_reg;
   idc_pkg::idc_seq_regs_t seq_next;

   // next state: load a word, offer it, step on acceptance
   always_comb begin
      seq_next = seq_reg;
      unique case (seq_reg.state)
         idc_pkg::IDC_IDLE: begin
            if (start_i) begin
               seq_next.idx   = '0;
               seq_next.state = idc_pkg::IDC_LOAD;
            end
         end
         idc_pkg::IDC_LOAD: begin
            seq_next.data  = word_i;
            seq_next.state = idc_pkg::IDC_SEND;
         end
         idc_pkg::IDC_SEND: begin
            if (ready_i) begin
               if (seq_reg.idx == LAST) begin
                  seq_next.state = idc_pkg::IDC_IDLE;
               end else begin
                  seq_next.idx   = seq_reg.idx + 8'h01;
                  seq_next.state = idc_pkg::IDC_LOAD;
               end
            end
         end
         default: begin
            seq_next.state = idc_pkg::IDC_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         seq_reg <= '{state: idc_pkg::IDC_IDLE, idx: 8'h00, data: 16'h0000};
      end else begin
         seq_reg <= seq_next;
      end
   end

   // outputs
   assign valid_o = (seq_reg.state == idc_pkg::IDC_SEND);
   assign busy_o  = (seq_reg.state != idc_pkg::IDC_IDLE);
   assign data_o  = seq_reg.data;
   assign idx_o   = seq_reg.idx;

endmodule

// >>> idc_identify_words.sv
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "idc_cfg.svh"

// Functional notes
// - word 63 high byte shows selected multiword DMA mode one-hot, bits 15-11 zero
// - word 63 low byte shows supported multiword DMA modes, bits 7-3 zero
// - word 53 bit 1 set whenever any field of words 63-68 is supported
// - word 64 bits 1-0 show PIO mode 4/3 support, rest zero
// - DMA modes above 2 and PIO modes above 4 never encoded here
// - word 65 holds minimum DMA cycle, never below fastest supported mode
// - word 66 holds recommended DMA cycle, never below word 65
// - words 65 and 66 provided for DMA mode 1 up, otherwise zero
// - word 67 holds PIO cycle without flow control, never below word 68
// - word 68 equals cycle time of fastest supported PIO mode
// - words 67 and 68 read zero when neither PIO mode 3 nor PIO mode 4 is supported
// - words 83 and 84 have bit 14 set, bit 15 clear; word 84 rest zero
// - word 82 bits 0,2,4,7,8,9,10 read zero
// - word 82 bits 3,12,13,14 read one
// - word 83 bits 0,1,4 zero, bit 2 one, bit 3 follows APM
// - word 53 bit 1 marks words 64-70 valid, clear means invalid
module idc_identify_words #(
   parameter int unsigned WORDS = `IDC_ID_WORDS
) (
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rstn_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // identify stream
   input  wire logic        id_start_i,
   input  wire logic        id_ready_i,
   output logic             id_valid_o,
   output logic [15:0]      id_word_o,
   output logic [7:0]       id_index_o,
   output logic             id_busy_o
);

   idc_pkg::idc_apb_regs_t rg_reg;
   idc_pkg::idc_apb_regs_t rg_next;

   logic [2:0]         mw_sup;
   logic [1:0]         pio_sup;
   logic [2:0]         mw_sel_hot;
   logic               mw_sel_ok;
   logic               dma_ok;
   logic               pio_ok;
   logic               fields_valid;
   idc_pkg::idc_word_t w53;
   idc_pkg::idc_word_t w63;
   idc_pkg::idc_word_t w64;
   idc_pkg::idc_word_t w65;
   idc_pkg::idc_word_t w66;
   idc_pkg::idc_word_t w67;
   idc_pkg::idc_word_t w68;
   idc_pkg::idc_word_t w82;
   idc_pkg::idc_word_t w83;
   idc_pkg::idc_word_t w84;
   idc_pkg::idc_word_t bus_word;
   idc_pkg::idc_word_t seq_word;
   idc_pkg::idc_idx_t  seq_idx;
   logic               setup;
   logic               access;
   logic [31:0]        pio_merge;

   // ****************************************************************
   // helper functions
   // ****************************************************************

   // larger of two cycle times
   function automatic logic [15:0] idc_max16(input logic [15:0] a, input logic [15:0] b);
      idc_max16 = (a > b) ? a : b;
   endfunction

   // cycle time of the fastest supported multiword DMA mode
   function automatic logic [15:0] idc_mw_floor(input logic [2:0] sup);
      if (sup[2]) begin
         idc_mw_floor = `IDC_MW2_NS;
      end else if (sup[1]) begin
         idc_mw_floor = `IDC_MW1_NS;
      end else if (sup[0]) begin
         idc_mw_floor = `IDC_MW0_NS;
      end else begin
         idc_mw_floor = 16'h0000;
      end
   endfunction

   // byte-lane merge of a write
   function automatic logic [31:0] idc_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
      for (int b = 0; b < 4; b++) begin
         idc_strb[8*b +: 8] = strb[b] ? new_v[8*b +: 8] : old_v[8*b +: 8];
      end
   endfunction

   // ****************************************************************
   // identify field words
   // ****************************************************************

   // capability fields, only modes 0-2 and PIO 3-4 exist here
   assign mw_sup  = rg_reg.cap[`IDC_CAP_MW_LSB +: 3];
   assign pio_sup = rg_reg.cap[`IDC_CAP_PIO_LSB +: 2];

   // selection shown only for a valid mode of 0 to 2 with some supported mode at or above it
   assign mw_sel_ok  = rg_reg.sel[`IDC_SEL_VALID] && (rg_reg.sel[2:0] <= 3'h2) &&
                       ((mw_sup >> rg_reg.sel[1:0]) != 3'h0);
   assign mw_sel_hot = mw_sel_ok ? 3'(3'b001 << rg_reg.sel[1:0]) : 3'h0;

   // field support flags
   assign dma_ok       = mw_sup[1] | mw_sup[2];
   assign pio_ok       = |pio_sup;
   assign fields_valid = (|mw_sup) | pio_ok;

   // word 53 carries only the validity bit
   assign w53 = {14'h0000, fields_valid, 1'b0};

   // mode words
   assign w63 = {5'h00, mw_sel_hot, 5'h00, mw_sup};
   assign w64 = {14'h0000, pio_sup};

   // dma cycle times, clamped to legal floors
   assign w65 = dma_ok ? idc_max16(rg_reg.dma_time[15:0], idc_mw_floor(mw_sup)) : 16'h0000;
   assign w66 = dma_ok ? idc_max16(rg_reg.dma_time[31:16], w65) : 16'h0000;

   // pio cycle times
   assign w68 = pio_ok ? (pio_sup[1] ? `IDC_PIO4_NS : `IDC_PIO3_NS) : 16'h0000;
   assign w67 = pio_ok ? idc_max16(rg_reg.pio_time, w68) : 16'h0000;

   // feature words
   assign w82 = `IDC_W82_FIXED |
                (16'(rg_reg.cap[`IDC_CAP_SEC]) << `IDC_W82_SEC) |
                (16'(rg_reg.cap[`IDC_CAP_WC]) << `IDC_W82_WC) |
                (16'(rg_reg.cap[`IDC_CAP_LA]) << `IDC_W82_LA);
   assign w83 = `IDC_W83_FIXED | (16'(rg_reg.cap[`IDC_CAP_APM]) << `IDC_W83_APM);
   assign w84 = `IDC_W84_FIXED;

   // ****************************************************************
   // word lookup and identify stream
   // ****************************************************************

   // software window onto the identify block
   idc_word_sel u_bus_sel (
      .idx_i  (rg_reg.widx),
      .w53_i  (w53),
      .w63_i  (w63),
      .w64_i  (w64),
      .w65_i  (w65),
      .w66_i  (w66),
      .w67_i  (w67),
      .w68_i  (w68),
      .w82_i  (w82),
      .w83_i  (w83),
      .w84_i  (w84),
      .word_o (bus_word)
   );

   // lookup for the streamed transfer
   idc_word_sel u_seq_sel (
      .idx_i  (seq_idx),
      .w53_i  (w53),
      .w63_i  (w63),
      .w64_i  (w64),
      .w65_i  (w65),
      .w66_i  (w66),
      .w67_i  (w67),
      .w68_i  (w68),
      .w82_i  (w82),
      .w83_i  (w83),
      .w84_i  (w84),
      .word_o (seq_word)
   );

   // walks the block in index order
   idc_stream_seq #(
      .WORDS (WORDS)
   ) u_seq (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .start_i   (id_start_i),
      .ready_i   (id_ready_i),
      .word_i    (seq_word),
      .idx_o     (seq_idx),
      .valid_o   (id_valid_o),
      .busy_o    (id_busy_o),
      .data_o    (id_word_o)
   );

   assign id_index_o = seq_idx;

   // ****************************************************************
   // apb register bank
   // ****************************************************************
   assign setup  = psel_i & ~penable_i;
   assign access = psel_i & penable_i;

   // pio time merge, only the low half is kept
   assign pio_merge = idc_strb({16'h0000, rg_reg.pio_time}, pwdata_i, pstrb_i);

   // read data and error latched in setup, writes land in access
   always_comb begin
      rg_next = rg_reg;
      if (setup) begin
         rg_next.err   = 1'b0;
         rg_next.rdata = 32'h0000_0000;
         case (paddr_i)
            `IDC_OFS_CAP:      rg_next.rdata = rg_reg.cap;
            `IDC_OFS_SEL:      rg_next.rdata = {28'h0000000, rg_reg.sel};
            `IDC_OFS_DMA_TIME: rg_next.rdata = rg_reg.dma_time;
            `IDC_OFS_PIO_TIME: rg_next.rdata = {16'h0000, rg_reg.pio_time};
            `IDC_OFS_WIDX:     rg_next.rdata = {24'h000000, rg_reg.widx};
            `IDC_OFS_WDATA:    rg_next.rdata = {16'h0000, bus_word};
            `IDC_OFS_STATUS:   rg_next.rdata = {23'h000000, id_busy_o, seq_idx};
            default:           rg_next.err   = 1'b1;
         endcase
      end
      if (access && pwrite_i) begin
         case (paddr_i)
            `IDC_OFS_CAP: begin
               rg_next.cap = idc_strb(rg_reg.cap, pwdata_i, pstrb_i) & `IDC_CAP_MASK;
            end
            `IDC_OFS_SEL: begin
               rg_next.sel = pstrb_i[0] ? pwdata_i[3:0] : rg_reg.sel;
            end
            `IDC_OFS_DMA_TIME: begin
               rg_next.dma_time = idc_strb(rg_reg.dma_time, pwdata_i, pstrb_i);
            end
            `IDC_OFS_PIO_TIME: begin
               rg_next.pio_time = pio_merge[15:0];
            end
            `IDC_OFS_WIDX: begin
               rg_next.widx = pstrb_i[0] ? pwdata_i[7:0] : rg_reg.widx;
            end
            default: begin
               rg_next.widx = rg_reg.widx;
            end
         endcase
      end
   end

   // register state
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rg_reg <= '{cap: `IDC_CAP_RST, sel: `IDC_SEL_RST, dma_time: `IDC_DMA_TIME_RST,
                     pio_time: `IDC_PIO_TIME_RST, widx: `IDC_WIDX_RST, rdata: 32'h0000_0000, err: 1'b0};
      end else begin
         rg_reg <= rg_next;
      end
   end

   // zero-wait slave
   assign prdata_o  = rg_reg.rdata;
   assign pslverr_o = rg_reg.err;
   assign pready_o  = 1'b1;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rstn_i);

   property p_w63_sel;
      (rg_reg.sel == 4'h9) && (mw_sup[2:1] != 2'b00) |-> (w63[15:8] == 8'h02);
   endproperty
   a_w63_sel: assert property (p_w63_sel) else $error("word 63 misses selected mode 1");

   property p_w63_res;
      $onehot0(w63[15:8]) && (w63[15:11] == 5'h00) && (w63[7:3] == 5'h00);
   endproperty
   a_w63_res: assert property (p_w63_res) else $error("word 63 reserved or one-hot broken");

   property p_w53_valid;
      w53[1] == ((w63[2:0] != 3'h0) || (w64[1:0] != 2'h0));
   endproperty
   a_w53_valid: assert property (p_w53_valid) else $error("word 53 validity bit wrong");

   property p_w64_res;
      (w64[15:2] == 14'h0000) && (w64[1:0] == rg_reg.cap[4:3]);
   endproperty
   a_w64_res: assert property (p_w64_res) else $error("word 64 content wrong");

   property p_dma_floor;
      dma_ok |-> (w65 >= idc_mw_floor(mw_sup)) && (w66 >= w65) && (w65 != 16'h0000);
   endproperty
   a_dma_floor: assert property (p_dma_floor) else $error("dma cycle times below floor");

   property p_dma_zero;
      !dma_ok |-> (w65 == 16'h0000) && (w66 == 16'h0000);
   endproperty
   a_dma_zero: assert property (p_dma_zero) else $error("dma cycle times not zero");

   property p_pio_times;
      pio_sup[1] |-> (w68 == `IDC_PIO4_NS) && (w67 >= w68);
   endproperty
   a_pio_times: assert property (p_pio_times) else $error("pio cycle times wrong");

   property p_pio_zero;
      (pio_sup == 2'b00) |-> (w67 == 16'h0000) && (w68 == 16'h0000);
   endproperty
   a_pio_zero: assert property (p_pio_zero) else $error("pio cycle times not zero");

   property p_feat;
      (w84 == 16'h4000) && (w83[15:14] == 2'b01) && ((w82 & 16'h779d) == 16'h7008) &&
      ((w83 & 16'h0017) == 16'h0004);
   endproperty
   a_feat: assert property (p_feat) else $error("feature word fixed bits wrong");

   property p_feat_opt;
      (w82[1] == rg_reg.cap[8]) && (w82[5] == rg_reg.cap[9]) && (w82[6] == rg_reg.cap[10]) &&
      (w83[3] == rg_reg.cap[11]);
   endproperty
   a_feat_opt: assert property (p_feat_opt) else $error("feature option bits wrong");

   property p_stream_step;
      id_valid_o && id_ready_i && (id_index_o != 8'hff) |->
         ##2 id_valid_o && (id_index_o == $past(id_index_o, 2) + 8'h01);
   endproperty
   a_stream_step: assert property (p_stream_step) else $error("stream index not in order");

   property p_stream_hold;
      id_valid_o && !id_ready_i |=> id_valid_o && $stable(id_word_o) && $stable(id_index_o);
   endproperty
   a_stream_hold: assert property (p_stream_hold) else $error("stream word dropped");

endmodule

// >>> idc_host_sink.sv
`timescale 1ns/1ps

// ****************************************************************
// identify data sink standing in for the ata host
// ****************************************************************
module idc_host_sink (
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rstn_i,
   // bench control
   input  wire logic        stall_i,
   input  wire logic        clr_i,
   input  wire logic [7:0]  rd_idx_i,
   // identify stream
   input  wire logic        id_valid_i,
   input  wire logic [15:0] id_word_i,
   input  wire logic [7:0]  id_index_i,
   output logic             id_ready_o,
   // capture results
   output logic [15:0]      rd_word_o,
   output logic [8:0]       count_o,
   output logic             order_ok_o,
   output logic             feat_ok_o,
   output logic             timing_ok_o
);
   logic [15:0] mem [0:255];
   logic [15:0] lfsr;

   // ready pattern, capture and order tracking
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         id_ready_o <= 1'b0;
         lfsr       <= 16'h0001;
         count_o    <= 9'h000;
         order_ok_o <= 1'b1;
      end else begin
         lfsr       <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
         id_ready_o <= stall_i ? lfsr[0] : 1'b1;
         if (clr_i) begin
            count_o    <= 9'h000;
            order_ok_o <= 1'b1;
         end else if (id_valid_i && id_ready_o) begin
            mem[id_index_i] <= id_word_i;
            count_o         <= count_o + 9'h001;
            if (id_index_i !== count_o[7:0]) order_ok_o <= 1'b0;
         end
      end
   end

   // host view: all-zero or all-one feature words mean not indicated, only reported
   assign feat_ok_o = mem[8'h52] != 16'h0000 && mem[8'h52] != 16'hffff && mem[8'h53] != 16'h0000 &&
                      mem[8'h53] != 16'hffff && mem[8'h54] != 16'h0000 && mem[8'h54] != 16'hffff;
   assign timing_ok_o = mem[8'h35][1];
   assign rd_word_o   = mem[rd_idx_i];
endmodule

// >>> idc_identify_words_tb.sv
`timescale 1ns/1ps
`include "idc_cfg.svh"

module idc_identify_words_tb;
   // ****************************************************************
   // bench signals
   // ****************************************************************
   logic        sys_clk_i = 1'b0;
   logic        rstn_i    = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0, stall = 1'b0, clr = 1'b0;
   logic [11:0] paddr  = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, cap, sel, dma, pio, rd;
   logic        pready, pslverr, ready, valid, busy, err, ord_ok, feat_ok, tim_ok;
   logic [15:0] word, hw;
   logic [7:0]  index, hidx = 8'h00;
   logic [8:0]  cnt;
   logic [3:0]  pstrb = 4'hf;
   int          fail_count = 0, compares = 0, seed = 32'h888208ee, k, j, n;
   int          idxs [0:9] = '{53, 63, 64, 65, 66, 67, 68, 82, 83, 84};
   logic [31:0] tbl [0:5] = '{32'h0, 32'h1, 32'h2, 32'h18, 32'h8, 32'hffff_ffff};

   always #12.5 sys_clk_i = ~sys_clk_i;

   idc_identify_words u_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .id_start_i(start), .id_ready_i(ready), .id_valid_o(valid),
      .id_word_o(word), .id_index_o(index), .id_busy_o(busy));

   idc_host_sink u_host (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .stall_i(stall), .clr_i(clr),
      .rd_idx_i(hidx), .id_valid_i(valid), .id_word_i(word), .id_index_i(index), .id_ready_o(ready),
      .rd_word_o(hw), .count_o(cnt), .order_ok_o(ord_ok), .feat_ok_o(feat_ok), .timing_ok_o(tim_ok));

   // ****************************************************************
   // checking, bus and reference tasks
   // ****************************************************************
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task end_sim;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // one apb transfer, held until pready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         fail_count++;
         end_sim;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk_i);
   endtask

   function logic [15:0] mx(input logic [15:0] a, input logic [15:0] b);
      return a > b ? a : b;
   endfunction

   // reference identify word from the current configuration
   function logic [15:0] ew(input int i);
      logic [2:0]  s;
      logic [1:0]  p;
      logic [15:0] w65;
      s = cap[2:0];
      p = cap[4:3];
      w65 = (s[2] | s[1]) ? mx(dma[15:0], s[2] ? `IDC_MW2_NS : `IDC_MW1_NS) : 16'h0;
      case (i)
         53: return (s != 3'h0 || p != 2'h0) ? 16'h0002 : 16'h0000;
         63: return {5'h0, (sel[3] && sel[2:0] <= 3'h2 && (s >> sel[2:0]) != 3'h0) ? 3'h1 << sel[2:0] : 3'h0, 5'h0, s};
         64: return {14'h0, p};
         65: return w65;
         66: return (s[2] | s[1]) ? mx(dma[31:16], w65) : 16'h0;
         67: return p != 2'h0 ? mx(pio[15:0], p[1] ? `IDC_PIO4_NS : `IDC_PIO3_NS) : 16'h0;
         68: return p[1] ? `IDC_PIO4_NS : (p[0] ? `IDC_PIO3_NS : 16'h0);
         82: return `IDC_W82_FIXED | {9'h0, cap[10], cap[9], 3'h0, cap[8], 1'b0};
         83: return `IDC_W83_FIXED | {12'h0, cap[11], 3'h0};
         84: return `IDC_W84_FIXED;
         default: return 16'h0000;
      endcase
   endfunction

   task chk_word(input int i, input logic [15:0] g);
      case (i)
         53: chk({16'h0, g}, {16'h0, ew(i)});
         63: chk({16'h0, g}, {16'h0, ew(i)});
         64: chk({16'h0, g}, {16'h0, ew(i)});
         65: chk({16'h0, g}, {16'h0, ew(i)});
         66: chk({16'h0, g}, {16'h0, ew(i)});
         67: chk({16'h0, g}, {16'h0, ew(i)});
         68: chk({16'h0, g}, {16'h0, ew(i)});
         82: chk({16'h0, g}, {16'h0, ew(i)});
         83: chk({16'h0, g}, {16'h0, ew(i)});
         84: chk({16'h0, g}, {16'h0, ew(i)});
         default: chk({16'h0, g}, {16'h0, ew(i)});
      endcase
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      repeat (5) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      @(posedge sys_clk_i);
      apb(1'b0, `IDC_OFS_CAP, 32'h0);
      chk(rd, `IDC_CAP_RST);
      for (k = 4; k <= 16; k += 4) begin
         apb(1'b0, k[11:0], 32'h0);
         chk(rd, 32'h0);
      end
      apb(1'b1, 12'h01c, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 12'h01c, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      apb(1'b1, `IDC_OFS_STATUS, 32'hffff_ffff);
      chk({31'h0, err}, 32'h0);
      // partial strobe write lands in the low lanes only
      pstrb <= 4'h3;
      apb(1'b1, `IDC_OFS_DMA_TIME, 32'hffff_ffff);
      pstrb <= 4'hf;
      apb(1'b0, `IDC_OFS_DMA_TIME, 32'h0);
      chk(rd, 32'h0000_ffff);
      for (k = 0; k < 12; k++) begin
         cap = k < 6 ? tbl[k] : $random(seed);
         sel = k < 6 ? 32'h9 : $random(seed);
         dma = $random(seed) & 32'h01ff_01ff;
         pio = $random(seed) & 32'h0000_01ff;
         stall <= k[0];
         apb(1'b1, `IDC_OFS_CAP, cap);
         apb(1'b1, `IDC_OFS_SEL, sel);
         apb(1'b1, `IDC_OFS_DMA_TIME, dma);
         apb(1'b1, `IDC_OFS_PIO_TIME, pio);
         cap &= `IDC_CAP_MASK;
         sel &= 32'hf;
         apb(1'b0, `IDC_OFS_CAP, 32'h0);
         chk(rd, cap);
         apb(1'b0, `IDC_OFS_SEL, 32'h0);
         chk(rd, sel);
         for (j = 0; j < 10; j++) begin
            apb(1'b1, `IDC_OFS_WIDX, idxs[j]);
            apb(1'b0, `IDC_OFS_WDATA, 32'h0);
            chk_word(idxs[j], rd[15:0]);
         end
         // full stream, with a second start while busy that must be ignored
         clr <= 1'b1;
         @(posedge sys_clk_i);
         clr <= 1'b0;
         start <= 1'b1;
         @(posedge sys_clk_i);
         start <= 1'b0;
         repeat (8) @(posedge sys_clk_i);
         start <= 1'b1;
         @(posedge sys_clk_i);
         start <= 1'b0;
         j = 0;
         while (busy !== 1'b0 && j < 4000) begin
            @(negedge sys_clk_i);
            j++;
         end
         if (j >= 4000) begin
            fail_count++;
            end_sim;
         end
         chk({23'h0, cnt}, 32'd256);
         chk({31'h0, ord_ok}, 32'h1);
         chk({31'h0, feat_ok}, 32'h1);
         chk({31'h0, tim_ok}, {31'h0, ew(53) != 16'h0});
         for (j = 0; j < 256; j++) begin
            hidx = j[7:0];
            #1;
            chk_word(j, hw);
         end
         @(posedge sys_clk_i);
      end
      end_sim;
   end

   // hang guard
   initial begin
      #2500000;
      fail_count++;
      end_sim;
   end
endmodule
